// [rtl/bpi_defs.svh]
// constants for the bit pattern interpolation block
`ifndef BPI_DEFS_SVH
`define BPI_DEFS_SVH
`define BPI_CMD_START   8'h34
`define BPI_CMD_WR_EN   8'h36
`define BPI_CMD_WR_DIS  8'h37
`define BPI_CMD_STACK   8'h38
`define BPI_CMD_CLEAR   8'h39
`define BPI_CMD_IRQ_CLR 8'h3d
`define BPI_MODE_IRQ_EN 15
`define BPI_MODE_SPD_HI 9
`define BPI_MODE_SPD_LO 8
`define BPI_ST_BUSY     8
`define BPI_ST_SC_HI    14
`define BPI_ST_SC_LO    13
`define BPI_SC_EMPTY    2'h0
`define BPI_SC_ONE      2'h1
`define BPI_SC_TWO      2'h2
`define BPI_SC_FULL     2'h3
`define BPI_LAST_SLOT   2'h2
`define BPI_LAST_UNIT   4'hf
`define BPI_SEL_XP      2'h0
`define BPI_SEL_XM      2'h1
`define BPI_SEL_YP      2'h2
`define BPI_SEL_YM      2'h3
`define BPI_STATUS_RST  16'h0000
`endif

// [rtl/bpi_pkg.sv]
// types shared by the bit pattern interpolation block
package bpi_pkg;
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_FETCH = 4'b0010,
        S_LOAD  = 4'b0100,
        S_UNIT  = 4'b1000
    } bpi_state_type;
    typedef logic [1:0]  bpi_ptr_type;
    typedef logic [63:0] bpi_set_type;
endpackage

// [rtl/bpi_stack_mem.sv]
// three-slot pattern set memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module bpi_stack_mem (
    input  wire logic                sys_clk,
    input  wire logic                nrst,
    input  wire logic                wr_en,
    input  wire bpi_pkg::bpi_ptr_type wr_addr,
    input  wire bpi_pkg::bpi_set_type wr_data,
    input  wire bpi_pkg::bpi_ptr_type rd_addr,
    output var  bpi_pkg::bpi_set_type rd_data
);
    import bpi_pkg::*;

    bpi_set_type mem [0:2];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 64'h0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

// [rtl/bpi_core.sv]
// two-axis bit pattern interpolation with stacking, interrupt and constant vector speed
`include "bpi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module bpi_core (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        cmd_wr,
    input  wire logic [7:0]  command_reg,
    input  wire logic        pat_wr,
    input  wire logic [1:0]  pat_sel,
    input  wire logic [15:0] pat_data,
    input  wire logic [15:0] mode_config_reg,
    input  wire logic [15:0] x_range_period,
    input  wire logic [15:0] y_range_period,
    input  wire logic [15:0] pulse_high_width,
    output logic             x_plus_pulse,
    output logic             x_minus_pulse,
    output logic             y_plus_pulse,
    output logic             y_minus_pulse,
    output logic             irq_out_n_o,
    output logic             irq_out_n_oe,
    output logic [15:0]      main_status_reg
);
    import bpi_pkg::*;

    function automatic bpi_ptr_type slot_inc(input bpi_ptr_type p);
        slot_inc = (p == `BPI_LAST_SLOT) ? 2'h0 : p + 2'h1;
    endfunction

    bpi_state_type state;
    bpi_state_type next_state;
    bpi_ptr_type   stack_count;
    bpi_ptr_type   next_count;
    bpi_ptr_type   wr_ptr;
    bpi_ptr_type   rd_ptr;
    bpi_set_type   cur_set;
    bpi_set_type   rd_data;
    logic [15:0]   stage [0:3];
    logic          wr_enabled;
    logic          irq_pending;
    logic [3:0]    bit_idx;
    logic [15:0]   unit_cnt;
    logic [15:0]   period_q;
    logic [15:0]   width_q;
    logic          cmd_start;
    logic          cmd_stack;
    logic          cmd_clear;
    logic          cmd_irq_clr;
    logic          push;
    logic          pop;
    logic          unit_start;
    logic          unit_end;
    logic          end_code;
    logic          finish;
    logic          bit_xp;
    logic          bit_xm;
    logic          bit_yp;
    logic          bit_ym;
    logic          vec_both;
    logic          irq_set;
    logic          irq_clr;

    assign cmd_start   = cmd_wr && (command_reg == `BPI_CMD_START);
    assign cmd_stack   = cmd_wr && (command_reg == `BPI_CMD_STACK);
    assign cmd_clear   = cmd_wr && (command_reg == `BPI_CMD_CLEAR);
    assign cmd_irq_clr = cmd_wr && (command_reg == `BPI_CMD_IRQ_CLR);

    // pattern bits for the current time unit, sets consumed lowest bit first
    assign bit_xp = cur_set[{2'h0, bit_idx}];
    assign bit_xm = cur_set[{2'h1, bit_idx}];
    assign bit_yp = cur_set[{2'h2, bit_idx}];
    assign bit_ym = cur_set[{2'h3, bit_idx}];

    assign unit_start = (state == S_UNIT) && (unit_cnt == 16'h0);
    assign unit_end   = (state == S_UNIT) && (unit_cnt != 16'h0)
                        && (({1'b0, unit_cnt} + 17'h1) >= {1'b0, period_q});
    assign end_code   = unit_start && bit_xp && bit_xm;
    assign pop        = unit_end && (bit_idx == `BPI_LAST_UNIT);
    assign push       = cmd_stack && (stack_count != `BPI_SC_FULL);
    assign vec_both   = (mode_config_reg[`BPI_MODE_SPD_HI:`BPI_MODE_SPD_LO] == 2'h1)
                        && (bit_xp ^ bit_xm) && (bit_yp ^ bit_ym);

    always_comb begin
        next_count = stack_count;
        if (cmd_clear || end_code) begin
            next_count = `BPI_SC_EMPTY;
        end else if (push && !pop) begin
            next_count = stack_count + 2'h1;
        end else if (pop && !push) begin
            next_count = stack_count - 2'h1;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (cmd_start && stack_count != `BPI_SC_EMPTY) begin
                    next_state = S_FETCH;
                end
            end
            S_FETCH: begin
                next_state = S_LOAD;
            end
            S_LOAD: begin
                next_state = S_UNIT;
            end
            S_UNIT: begin
                if (end_code) begin
                    next_state = S_IDLE;
                end else if (pop) begin
                    next_state = (next_count == `BPI_SC_EMPTY) ? S_IDLE : S_FETCH;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        if (cmd_clear) begin
            next_state = S_IDLE;
        end
    end

    assign finish  = (state != S_IDLE) && (next_state == S_IDLE);
    assign irq_set = (state != S_IDLE) && mode_config_reg[`BPI_MODE_IRQ_EN]
                     && (stack_count == `BPI_SC_TWO) && (next_count == `BPI_SC_ONE);
    assign irq_clr = cmd_stack || cmd_irq_clr || finish;

    bpi_stack_mem u_mem (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .wr_en   (push),
        .wr_addr (wr_ptr),
        .wr_data ({stage[3], stage[2], stage[1], stage[0]}),
        .rd_addr (rd_ptr),
        .rd_data (rd_data)
    );

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_enabled <= 1'b0;
        end else if (cmd_wr && command_reg == `BPI_CMD_WR_EN) begin
            wr_enabled <= 1'b1;
        end else if (cmd_wr && command_reg == `BPI_CMD_WR_DIS) begin
            wr_enabled <= 1'b0;
        end
    end

    // staging words; a full stack refuses them so a held set is never corrupted
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stage[0] <= 16'h0;
            stage[1] <= 16'h0;
            stage[2] <= 16'h0;
            stage[3] <= 16'h0;
        end else if (pat_wr && wr_enabled && stack_count != `BPI_SC_FULL) begin
            stage[pat_sel] <= pat_data;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stack_count <= `BPI_SC_EMPTY;
            wr_ptr      <= 2'h0;
            rd_ptr      <= 2'h0;
        end else begin
            stack_count <= next_count;
            if (cmd_clear || end_code) begin
                wr_ptr <= 2'h0;
                rd_ptr <= 2'h0;
            end else begin
                if (push) begin
                    wr_ptr <= slot_inc(wr_ptr);
                end
                if (pop) begin
                    rd_ptr <= slot_inc(rd_ptr);
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cur_set  <= 64'h0;
            bit_idx  <= 4'h0;
            unit_cnt <= 16'h0;
            period_q <= 16'h0;
            width_q  <= 16'h0;
        end else if (state == S_LOAD) begin
            cur_set  <= rd_data;
            bit_idx  <= 4'h0;
            unit_cnt <= 16'h0;
        end else if (state == S_UNIT) begin
            if (unit_start) begin
                period_q <= vec_both ? y_range_period : x_range_period;
                width_q  <= pulse_high_width;
                unit_cnt <= 16'h1;
            end else if (unit_end) begin
                unit_cnt <= 16'h0;
                bit_idx  <= bit_idx + 4'h1;
            end else begin
                unit_cnt <= unit_cnt + 16'h1;
            end
        end
    end

    // pulses rise at unit start and fall after the fixed high width
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            x_plus_pulse  <= 1'b0;
            x_minus_pulse <= 1'b0;
            y_plus_pulse  <= 1'b0;
            y_minus_pulse <= 1'b0;
        end else if (unit_start && !end_code && !cmd_clear) begin
            x_plus_pulse  <= bit_xp && !bit_xm;
            x_minus_pulse <= bit_xm && !bit_xp;
            y_plus_pulse  <= bit_yp && !bit_ym;
            y_minus_pulse <= bit_ym && !bit_yp;
        end else if (state != S_UNIT || unit_cnt == width_q) begin
            x_plus_pulse  <= 1'b0;
            x_minus_pulse <= 1'b0;
            y_plus_pulse  <= 1'b0;
            y_minus_pulse <= 1'b0;
        end
    end

    // set wins over a clear arriving in the same cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_pending <= 1'b0;
        end else if (irq_set) begin
            irq_pending <= 1'b1;
        end else if (irq_clr) begin
            irq_pending <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_out_n_o  <= 1'b0;
            irq_out_n_oe <= 1'b1;
        end else begin
            irq_out_n_o  <= 1'b0;
            irq_out_n_oe <= !(irq_set || (irq_pending && !irq_clr));
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            main_status_reg <= `BPI_STATUS_RST;
        end else begin
            main_status_reg <= `BPI_STATUS_RST;
            main_status_reg[`BPI_ST_SC_HI:`BPI_ST_SC_LO] <= next_count;
            main_status_reg[`BPI_ST_BUSY] <= (next_state != S_IDLE);
        end
    end

    irq_on_drop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        irq_set |=> !irq_out_n_oe) else $error("irq not raised on count drop");
    irq_masked_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (irq_out_n_oe && !mode_config_reg[`BPI_MODE_IRQ_EN]) |=> irq_out_n_oe)
        else $error("irq raised while disabled");
    irq_stack_rel_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (cmd_stack && !irq_set) |=> irq_out_n_oe) else $error("stack command left irq low");
    irq_clr_rel_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (cmd_irq_clr && !irq_set) |=> irq_out_n_oe) else $error("irq clear command ignored");
    irq_end_rel_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $fell(main_status_reg[`BPI_ST_BUSY]) |-> irq_out_n_oe) else $error("irq held after finish");
    full_refuse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (pat_wr && stack_count == `BPI_SC_FULL) |=> stage[$past(pat_sel)] == $past(stage[pat_sel]))
        else $error("pattern write taken with full stack");
    count_push_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (push && !pop && !cmd_clear && !end_code) |=> stack_count == $past(stack_count) + 2'h1)
        else $error("push did not raise count");
    pulse_width_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (x_plus_pulse || x_minus_pulse || y_plus_pulse || y_minus_pulse)
        |-> (unit_cnt >= 16'h1 && unit_cnt <= width_q)) else $error("pulse width wrong");
    vector_period_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (unit_start && !end_code && !cmd_clear)
        |=> period_q == ($past(vec_both) ? $past(y_range_period) : $past(x_range_period)))
        else $error("wrong range chosen for period");
    end_code_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        end_code |=> (stack_count == `BPI_SC_EMPTY) && !main_status_reg[`BPI_ST_BUSY])
        else $error("end code did not stop");
    pulse_map_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (unit_start && !end_code && !cmd_clear) |=> x_plus_pulse == $past(bit_xp && !bit_xm)
        && y_minus_pulse == $past(bit_ym && !bit_yp)) else $error("pulse does not follow bit");
endmodule
`default_nettype wire

// [verif/bpi_host_model.sv]
// host cpu model driving the command, pattern and setup ports
`include "bpi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module bpi_host_model (
    input  wire logic   sys_clk,
    input  wire logic   irq_out_n_o,
    input  wire logic   irq_out_n_oe,
    output logic        cmd_wr,
    output logic [7:0]  command_reg,
    output logic        pat_wr,
    output logic [1:0]  pat_sel,
    output logic [15:0] pat_data,
    output logic [15:0] mode_config_reg,
    output logic [15:0] x_range_period,
    output logic [15:0] y_range_period,
    output logic [15:0] pulse_high_width,
    output wire logic   irq_line
);
    // the request pin is open drain; the host board pulls it up
    assign irq_line = irq_out_n_oe ? 1'b1 : irq_out_n_o;
    initial begin
        cmd_wr = 1'b0;
        command_reg = 8'h00;
        pat_wr = 1'b0;
        pat_sel = 2'h0;
        pat_data = 16'h0000;
        mode_config_reg = 16'h0000;
        x_range_period = 16'h0005;
        y_range_period = 16'h0007;
        pulse_high_width = 16'h0002;
    end
    // released command and data buses show the inverse so stale values never look valid; pat_sel keeps its value
    task automatic cmd(input logic [7:0] code);
        @(posedge sys_clk);
        #1;
        cmd_wr = 1'b1;
        command_reg = code;
        @(posedge sys_clk);
        #1;
        cmd_wr = 1'b0;
        command_reg = ~code;
    endtask
    task automatic pat(input logic [1:0] sel, input logic [15:0] d);
        @(posedge sys_clk);
        #1;
        pat_wr = 1'b1;
        pat_sel = sel;
        pat_data = d;
        @(posedge sys_clk);
        #1;
        pat_wr = 1'b0;
        pat_data = ~d;
    endtask
    task automatic load_set(input logic [15:0] xp, input logic [15:0] xm, input logic [15:0] yp,
                            input logic [15:0] ym);
        pat(`BPI_SEL_XP, xp);
        pat(`BPI_SEL_XM, xm);
        pat(`BPI_SEL_YP, yp);
        pat(`BPI_SEL_YM, ym);
        cmd(`BPI_CMD_STACK);
    endtask
    task automatic setup(input logic [15:0] mode);
        mode_config_reg = mode;
        y_range_period = 16'h0007;
        cmd(`BPI_CMD_CLEAR);
        cmd(`BPI_CMD_WR_EN);
    endtask
endmodule
`default_nettype wire

// [verif/tb_bpi_core.sv]
// self-checking bench for the pattern interpolation core
`include "bpi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_bpi_core;
    logic sys_clk;
    logic nrst;
    wire logic cmd_wr, pat_wr, xp, xm, yp, ym, irq_o, irq_oe, irq_line;
    wire logic [7:0] command_reg;
    wire logic [1:0] pat_sel;
    wire logic [15:0] pat_data, mode, xr, yr, hw_in, main_status_reg;
    int n_fail, cmp_count, cyc, last_rise, hw, exp_per;
    int cnt[4];
    int seq[$];
    int exq[$];
    logic chk_per;
    logic [3:0] prev, pl;
    bpi_core u_bpi_core (.sys_clk(sys_clk), .nrst(nrst), .cmd_wr(cmd_wr), .command_reg(command_reg),
        .pat_wr(pat_wr), .pat_sel(pat_sel), .pat_data(pat_data), .mode_config_reg(mode),
        .x_range_period(xr), .y_range_period(yr), .pulse_high_width(hw_in), .x_plus_pulse(xp),
        .x_minus_pulse(xm), .y_plus_pulse(yp), .y_minus_pulse(ym), .irq_out_n_o(irq_o),
        .irq_out_n_oe(irq_oe), .main_status_reg(main_status_reg));
    bpi_host_model u_bpi_host_model (.sys_clk(sys_clk), .irq_out_n_o(irq_o), .irq_out_n_oe(irq_oe),
        .cmd_wr(cmd_wr), .command_reg(command_reg), .pat_wr(pat_wr), .pat_sel(pat_sel),
        .pat_data(pat_data), .mode_config_reg(mode), .x_range_period(xr), .y_range_period(yr),
        .pulse_high_width(hw_in), .irq_line(irq_line));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    function automatic logic [15:0] st(input logic [1:0] sc, input logic busy);
        st = 16'h0000;
        st[`BPI_ST_SC_HI:`BPI_ST_SC_LO] = sc;
        st[`BPI_ST_BUSY] = busy;
    endfunction
    // polls the status word the way the host would, with a bound
    task automatic wait_st(input logic [15:0] e, input int lim);
        int i;
        i = 0;
        while (main_status_reg !== e && i < lim) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        chk("status", main_status_reg, e);
    endtask
    task automatic start_run(input int per);
        for (int k = 0; k < 4; k++) cnt[k] = 0;
        seq.delete();
        last_rise = 0;
        exp_per = per;
        u_bpi_host_model.cmd(`BPI_CMD_START);
    endtask
    task automatic run_one(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
                           input logic [15:0] d, input int per);
        u_bpi_host_model.setup(16'h0100);
        u_bpi_host_model.load_set(a, b, c, d);
        chk("status", main_status_reg, st(2'h1, 1'b0));
        start_run(per);
        chk_per = 1'b1;
        wait_st(st(2'h0, 1'b0), 400);
        chk_per = 1'b0;
    endtask
    // pulse monitor: counts and order of all four pulses, width and spacing of x plus pulses
    always @(posedge sys_clk) begin
        pl = {ym, yp, xm, xp};
        cyc++;
        for (int k = 0; k < 4; k++) if (pl[k] && !prev[k]) seq.push_back(k);
        for (int k = 0; k < 4; k++) if (pl[k] && !prev[k]) cnt[k]++;
        if (pl[0] && !prev[0]) begin
            if (chk_per && last_rise > 0) chk("period", 16'(cyc - last_rise), 16'(exp_per));
            last_rise = cyc;
        end
        if (pl[0]) hw++;
        else if (prev[0]) begin
            chk("high width", 16'(hw), 16'h0002);
            hw = 0;
        end
        prev = pl;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        end_of_test();
    end
    initial begin
        nrst = 1'b0;
        chk_per = 1'b0;
        prev = 4'h0;
        hw = 0;
        repeat (6) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        chk("status", main_status_reg, `BPI_STATUS_RST);
        chk("irq line", 16'(irq_line), 16'h0001);
        run_one(16'hffff, 16'h0000, 16'h0000, 16'h0000, 5);
        chk("x plus count", 16'(cnt[0]), 16'h0010);
        chk("y count", 16'(cnt[2] + cnt[3] + cnt[1]), 16'h0000);
        run_one(16'hffff, 16'h0000, 16'h0000, 16'hffff, 7);
        chk("y minus count", 16'(cnt[3]), 16'h0010);
        // end code at unit 2 must stop before the second set runs
        u_bpi_host_model.setup(16'h0000);
        u_bpi_host_model.load_set(16'h0004, 16'h0006, 16'hffff, 16'h0000);
        u_bpi_host_model.load_set(16'hffff, 16'h0000, 16'h0000, 16'h0000);
        start_run(5);
        wait_st(st(2'h0, 1'b0), 40);
        chk("end code x plus", 16'(cnt[0]), 16'h0000);
        chk("end code x minus", 16'(cnt[1]), 16'h0001);
        chk("end code y plus", 16'(cnt[2]), 16'h0002);
        chk("end code y minus", 16'(cnt[3]), 16'h0000);
        // stacked run with interrupt service
        u_bpi_host_model.setup(16'h8000);
        u_bpi_host_model.load_set(16'h0001, 16'h0002, 16'h0000, 16'h0000);
        u_bpi_host_model.load_set(16'h0000, 16'h0001, 16'h0000, 16'h0000);
        u_bpi_host_model.load_set(16'h0000, 16'h0000, 16'hffff, 16'h0000);
        u_bpi_host_model.cmd(`BPI_CMD_STACK);
        // a pattern word offered to a full stack must be dropped
        u_bpi_host_model.pat(`BPI_SEL_YM, 16'hffff);
        chk("full stack", main_status_reg, st(2'h3, 1'b0));
        start_run(5);
        wait_st(st(2'h2, 1'b1), 200);
        chk("irq at 3 to 2", 16'(irq_line), 16'h0001);
        wait_st(st(2'h1, 1'b1), 200);
        @(posedge sys_clk);
        #1;
        chk("irq at 2 to 1", 16'(irq_line), 16'h0000);
        u_bpi_host_model.load_set(16'h0000, 16'h0000, 16'h0000, 16'h0001);
        chk("irq after stack", 16'(irq_oe), 16'h0001);
        chk("status", main_status_reg, st(2'h2, 1'b1));
        wait_st(st(2'h1, 1'b1), 200);
        @(posedge sys_clk);
        #1;
        chk("irq again", 16'(irq_oe), 16'h0000);
        u_bpi_host_model.cmd(`BPI_CMD_IRQ_CLR);
        chk("irq after clear", 16'(irq_oe), 16'h0001);
        u_bpi_host_model.cmd(`BPI_CMD_WR_DIS);
        wait_st(st(2'h0, 1'b0), 200);
        exq = {0, 1, 1};
        repeat (16) exq.push_back(2);
        exq.push_back(3);
        chk("pulse total", 16'(seq.size()), 16'(exq.size()));
        foreach (exq[i]) if (i < seq.size()) chk("pulse order", 16'(seq[i]), 16'(exq[i]));
        // with and without enable; a pending request clears at the end
        foreach (exq[i]) if (i < 2) begin
            u_bpi_host_model.setup(i ? 16'h8000 : 16'h0000);
            u_bpi_host_model.load_set(16'h0000, 16'h0000, 16'h0000, 16'h0000);
            u_bpi_host_model.load_set(16'h0000, 16'h0000, 16'h0000, 16'h0000);
            start_run(5);
            wait_st(st(2'h1, 1'b1), 200);
            @(posedge sys_clk);
            #1;
            chk("irq enable", 16'(irq_line), i ? 16'h0000 : 16'h0001);
            wait_st(st(2'h0, 1'b0), 200);
            chk("irq at finish", 16'(irq_oe), 16'h0001);
        end
        // reset in mid-run must drop the request and empty the stack at once
        u_bpi_host_model.setup(16'h8000);
        u_bpi_host_model.load_set(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        u_bpi_host_model.load_set(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        start_run(5);
        wait_st(st(2'h1, 1'b1), 200);
        @(posedge sys_clk);
        #1;
        chk("irq before reset", 16'(irq_line), 16'h0000);
        nrst = 1'b0;
        @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        chk("status after reset", main_status_reg, `BPI_STATUS_RST);
        chk("irq after reset", 16'(irq_line), 16'h0001);
        chk("pulses after reset", 16'({ym, yp, xm, xp}), 16'h0000);
        end_of_test();
    end
endmodule
`default_nettype wire
